/* hw/sclx_pkg.sv */
package sclx_pkg;
   // register offsets on the plain register port
   localparam logic [1:0] SCLX_OFS_STATUS_TWO = 2'h0;
   localparam logic [1:0] SCLX_OFS_CONTROL_THREE = 2'h1;
   // serial_status_two field positions
   localparam int SCLX_S2_BRK_FLAG = 7;
   localparam int SCLX_S2_EDGE_FLAG = 6;
   localparam int SCLX_S2_RX_INV = 4;
   localparam int SCLX_S2_IDLE_SEL = 3;
   localparam int SCLX_S2_LONG_BRK = 2;
   localparam int SCLX_S2_BRK_DET_EN = 1;
   localparam int SCLX_S2_RX_ACTIVE = 0;
   // serial_control_three field positions
   localparam int SCLX_C3_RX_NINTH = 7;
   localparam int SCLX_C3_TX_NINTH = 6;
   localparam int SCLX_C3_TX_DIR = 5;
   localparam int SCLX_C3_TX_INV = 4;
   localparam int SCLX_C3_OR_IE = 3;
   localparam int SCLX_C3_NF_IE = 2;
   localparam int SCLX_C3_FE_IE = 1;
   localparam int SCLX_C3_PF_IE = 0;
   // reset values
   localparam logic [7:0] SCLX_RST_STATUS_TWO = 8'h00;
   localparam logic [7:0] SCLX_RST_CONTROL_THREE = 8'h00;
   // frame and break lengths in bit times, eight-bit mode except SCLX_FRAME_BITS_9
   localparam logic [3:0] SCLX_FRAME_BITS_8 = 4'ha;
   localparam logic [3:0] SCLX_FRAME_BITS_9 = 4'hb;
   localparam logic [3:0] SCLX_BRK_TX_SHORT = 4'ha;
   localparam logic [3:0] SCLX_BRK_TX_LONG = 4'hd;
   localparam logic [3:0] SCLX_BRK_DET_SHORT = 4'ha;
   localparam logic [3:0] SCLX_BRK_DET_LONG = 4'hb;
   // nine-bit mode lengthens every figure by this many bit times
   localparam logic [3:0] SCLX_NINTH_EXTRA = 4'h1;

   // receive line activity
   typedef enum logic {SCLX_LINE_IDLE, SCLX_LINE_BUSY} sclx_line_t;

   // picks a short or long length and adds the ninth-bit extension
   function automatic logic [3:0] sclx_len(input logic nine, input logic long_sel,
                                           input logic [3:0] short_len,
                                           input logic [3:0] long_len);
      logic [3:0] base;
      base = long_sel ? long_len : short_len;
      return nine ? base + SCLX_NINTH_EXTRA : base;
   endfunction
endpackage

/* hw/sclx_rx_line.sv */
`timescale 1ns/1ns
// receive line conditioner: pin sync, source select, inversion, run counters
module sclx_rx_line import sclx_pkg::*; #(
   parameter int CNT_W = 4
) (
   input wire logic clk_i, // bus clock
   input wire logic rst_i, // async reset, active high
   input wire logic rx_pin_i, // receive pin, asynchronous
   input wire logic tx_pin_i, // transmit pin read back, asynchronous
   input wire logic tx_serial_i, // internal transmit serial stream
   input wire logic loop_mode_i, // loop operation
   input wire logic loop_src_i, // loop source from transmit pin
   input wire logic rx_invert_i, // invert receive input
   input wire logic nine_bit_i, // nine data bits per frame
   input wire logic bit_tick_i, // one pulse per bit time
   input wire logic [3:0] break_thresh_i, // low bit times that make a break
   output logic line_o, // conditioned line level
   output logic edge_o, // active edge pulse
   output logic break_o, // break threshold reached pulse
   output logic idle_o, // idle line seen after activity pulse
   output logic busy_o // receiver active level
);
   // counters must hold the longest threshold of twelve
   if (CNT_W < 4) begin : g_bad_width
      $error("sclx_rx_line: CNT_W must be at least 4");
   end

   logic [1:0] pin_meta; // first sync stage, read only by pin_sync
   logic [1:0] pin_sync; // synchronised {tx pin, rx pin}
   logic raw_line; // selected source before inversion
   logic line_q; // previous conditioned level
   logic [CNT_W-1:0] low_cnt; // consecutive low bit times
   logic [CNT_W-1:0] high_cnt; // consecutive high bit times while busy
   logic [3:0] frame_len; // bit times that make an idle character
   sclx_line_t state; // receiver activity

   // two-stage synchroniser; idle line is high so reset to ones
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_meta <= 2'h3;
         pin_sync <= 2'h3;
      end else begin
         pin_meta <= {tx_pin_i, rx_pin_i};
         pin_sync <= pin_meta;
      end
   end

   // single-wire takes the transmit pin, plain loop the internal stream
   assign raw_line = loop_mode_i ? (loop_src_i ? pin_sync[1] : tx_serial_i) : pin_sync[0];
   // inversion sits ahead of every consumer of the line
   assign line_o = raw_line ^ rx_invert_i;
   assign frame_len = nine_bit_i ? SCLX_FRAME_BITS_9 : SCLX_FRAME_BITS_8;

   // edge history; a change of rx_invert_i can itself look like an edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_q <= 1'b1;
      end else begin
         line_q <= line_o;
      end
   end
   assign edge_o = line_q & ~line_o;

   // low run counter saturates so one long break reports once
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_cnt <= '0;
      end else if (bit_tick_i) begin
         if (line_o) begin
            low_cnt <= '0;
         end else if (low_cnt != '1) begin
            low_cnt <= low_cnt + 1'b1;
         end
      end
   end
   assign break_o = bit_tick_i & ~line_o & (low_cnt == CNT_W'(break_thresh_i - 4'h1));

   // activity state: start edge opens, a full idle character closes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= SCLX_LINE_IDLE;
      end else begin
         case (state)
            SCLX_LINE_IDLE: if (edge_o) state <= SCLX_LINE_BUSY;
            SCLX_LINE_BUSY: if (idle_o) state <= SCLX_LINE_IDLE;
            default: state <= SCLX_LINE_IDLE;
         endcase
      end
   end

   // high run counter, only meaningful while busy
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         high_cnt <= '0;
      end else if (state == SCLX_LINE_IDLE || (bit_tick_i && !line_o)) begin
         high_cnt <= '0;
      end else if (bit_tick_i && high_cnt != '1) begin
         high_cnt <= high_cnt + 1'b1;
      end
   end
   assign idle_o = (state == SCLX_LINE_BUSY) & bit_tick_i & line_o &
                   (high_cnt == CNT_W'(frame_len - 4'h1));
   assign busy_o = (state == SCLX_LINE_BUSY);
endmodule

/* hw/sclx_top.sv */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ns
module sclx_top import sclx_pkg::*; #(
   parameter int CNT_W = 4
) (
   input wire logic clk_i, // bus clock, 10 MHz
   input wire logic rst_i, // async reset, active high
   input wire logic [1:0] reg_addr_i, // register address
   input wire logic [7:0] reg_wdata_i, // register write data
   input wire logic reg_wr_i, // write strobe
   input wire logic reg_rd_i, // read strobe
   output logic [7:0] reg_rdata_o, // read data, cycle after read
   input wire logic rx_pin_i, // receive pin
   input wire logic tx_pin_i, // transmit pin level read back
   output logic tx_pin_o, // transmit pin drive value
   output logic tx_pin_oe_o, // transmit pin drive enable
   input wire logic bit_tick_i, // one pulse per bit time
   input wire logic nine_bit_mode_i, // nine data bits per frame
   input wire logic loop_mode_i, // loop operation
   input wire logic loop_source_select_i, // loop source is the transmit pin
   input wire logic receiver_standby_i, // receiver in standby
   input wire logic tx_serial_i, // transmit shifter output, true polarity
   input wire logic [7:0] tx_data_i, // byte written to the data register
   input wire logic tx_data_wr_i, // data register write pulse
   output logic [8:0] tx_word_o, // word handed to the transmit shifter
   output logic [3:0] break_len_o, // transmit break length, bit times
   output logic [3:0] frame_bits_o, // frame length, bit times
   input wire logic rx_char_done_i, // receive shifter finished a character
   input wire logic rx_stop_err_i, // that character had a low stop bit
   input wire logic rx_bit8_i, // ninth bit of that character
   output logic rx_line_o, // conditioned receive level for the shifter
   output logic rx_full_set_o, // pulse: set the receive full flag
   output logic framing_set_o, // pulse: set the framing error flag
   output logic idle_set_o, // pulse: set the idle flag
   input wire logic overrun_flag_i, // primary overrun flag
   input wire logic noise_flag_i, // primary noise flag
   input wire logic framing_error_flag_i, // primary framing error flag
   input wire logic parity_error_flag_i, // primary parity error flag
   output logic err_irq_o // error interrupt request, level
);
   logic brk_flag; // break_detect_flag
   logic edge_flag; // rx_edge_flag
   logic rx_invert; // rx_polarity_invert
   logic idle_sel; // standby_idle_flag_select
   logic long_brk_sel; // long_break_select
   logic brk_det_en; // long_break_detect_enable
   logic rx_ninth; // rx_ninth_bit
   logic tx_ninth; // tx_ninth_bit
   logic tx_dir; // single_wire_direction
   logic tx_invert; // tx_polarity_invert
   logic [3:0] irq_en; // {overrun, noise, framing, parity} enables
   logic wr_s2; // write to serial_status_two
   logic wr_c3; // write to serial_control_three
   logic [7:0] status_two; // assembled status view
   logic [7:0] control_three; // assembled control view
   logic [3:0] brk_thresh; // break detection threshold
   logic line_level; // conditioned receive level
   logic line_edge; // active edge pulse
   logic line_break; // break threshold pulse
   logic line_idle; // idle line pulse
   logic rx_busy; // receiver active level
   logic single_wire; // single-wire half-duplex configuration
   logic char_accept; // character allowed to reach the buffer

   assign wr_s2 = reg_wr_i && (reg_addr_i == SCLX_OFS_STATUS_TWO);
   assign wr_c3 = reg_wr_i && (reg_addr_i == SCLX_OFS_CONTROL_THREE);

   // line conditioning, run counters and receiver activity
   sclx_rx_line #(
      .CNT_W(CNT_W)
   ) u_line (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rx_pin_i(rx_pin_i),
      .tx_pin_i(tx_pin_i),
      .tx_serial_i(tx_serial_i),
      .loop_mode_i(loop_mode_i),
      .loop_src_i(loop_source_select_i),
      .rx_invert_i(rx_invert),
      .nine_bit_i(nine_bit_mode_i),
      .bit_tick_i(bit_tick_i),
      .break_thresh_i(brk_thresh),
      .line_o(line_level),
      .edge_o(line_edge),
      .break_o(line_break),
      .idle_o(line_idle),
      .busy_o(rx_busy)
   );

   // threshold grows by one bit time when detection is enabled
   assign brk_thresh = sclx_len(nine_bit_mode_i, brk_det_en,
                                SCLX_BRK_DET_SHORT, SCLX_BRK_DET_LONG);

   // control fields of serial_status_two, software owned
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_invert <= SCLX_RST_STATUS_TWO[SCLX_S2_RX_INV];
         idle_sel <= SCLX_RST_STATUS_TWO[SCLX_S2_IDLE_SEL];
         long_brk_sel <= SCLX_RST_STATUS_TWO[SCLX_S2_LONG_BRK];
         brk_det_en <= SCLX_RST_STATUS_TWO[SCLX_S2_BRK_DET_EN];
      end else if (wr_s2) begin
         rx_invert <= reg_wdata_i[SCLX_S2_RX_INV];
         idle_sel <= reg_wdata_i[SCLX_S2_IDLE_SEL];
         long_brk_sel <= reg_wdata_i[SCLX_S2_LONG_BRK];
         brk_det_en <= reg_wdata_i[SCLX_S2_BRK_DET_EN];
      end
   end

   // break flag: a new break wins over a write-one in the same cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         brk_flag <= SCLX_RST_STATUS_TWO[SCLX_S2_BRK_FLAG];
      end else if (line_break && brk_det_en) begin
         brk_flag <= 1'b1;
      end else if (wr_s2 && reg_wdata_i[SCLX_S2_BRK_FLAG]) begin
         brk_flag <= 1'b0;
      end
   end

   // edge flag: same set-over-clear priority
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         edge_flag <= SCLX_RST_STATUS_TWO[SCLX_S2_EDGE_FLAG];
      end else if (line_edge) begin
         edge_flag <= 1'b1;
      end else if (wr_s2 && reg_wdata_i[SCLX_S2_EDGE_FLAG]) begin
         edge_flag <= 1'b0;
      end
   end

   // writable fields of serial_control_three; the ninth receive bit is not among them
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_ninth <= SCLX_RST_CONTROL_THREE[SCLX_C3_TX_NINTH];
         tx_dir <= SCLX_RST_CONTROL_THREE[SCLX_C3_TX_DIR];
         tx_invert <= SCLX_RST_CONTROL_THREE[SCLX_C3_TX_INV];
         irq_en <= SCLX_RST_CONTROL_THREE[SCLX_C3_OR_IE:SCLX_C3_PF_IE];
      end else if (wr_c3) begin
         tx_ninth <= reg_wdata_i[SCLX_C3_TX_NINTH];
         tx_dir <= reg_wdata_i[SCLX_C3_TX_DIR];
         tx_invert <= reg_wdata_i[SCLX_C3_TX_INV];
         irq_en <= reg_wdata_i[SCLX_C3_OR_IE:SCLX_C3_PF_IE];
      end
   end

   // while break detection is on, no character reaches the buffer
   assign char_accept = rx_char_done_i && !brk_det_en;

   // ninth receive bit moves only with a buffered character
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_ninth <= SCLX_RST_CONTROL_THREE[SCLX_C3_RX_NINTH];
      end else if (char_accept && nine_bit_mode_i) begin
         rx_ninth <= rx_bit8_i;
      end
   end

   // receive flag requests to the primary status logic
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_full_set_o <= 1'b0;
         framing_set_o <= 1'b0;
      end else begin
         rx_full_set_o <= char_accept;
         // long break select plays no part in framing decisions
         framing_set_o <= char_accept && rx_stop_err_i;
      end
   end

   // idle pulse is withheld in standby unless software asked for it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         idle_set_o <= 1'b0;
      end else begin
         idle_set_o <= line_idle && (!receiver_standby_i || idle_sel);
      end
   end

   // transmit word latched on the data write; the ninth bit is held, not consumed
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_word_o <= 9'h000;
      end else if (tx_data_wr_i) begin
         tx_word_o <= {nine_bit_mode_i & tx_ninth, tx_data_i};
      end
   end

   // frame geometry for the shifters
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         break_len_o <= SCLX_BRK_TX_SHORT;
         frame_bits_o <= SCLX_FRAME_BITS_8;
      end else begin
         break_len_o <= sclx_len(nine_bit_mode_i, long_brk_sel,
                                 SCLX_BRK_TX_SHORT, SCLX_BRK_TX_LONG);
         frame_bits_o <= nine_bit_mode_i ? SCLX_FRAME_BITS_9 : SCLX_FRAME_BITS_8;
      end
   end

   // transmit pin; registered, so it trails the shifter by one bus clock
   assign single_wire = loop_mode_i && loop_source_select_i;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_pin_o <= 1'b1;
         tx_pin_oe_o <= 1'b1;
         rx_line_o <= 1'b1;
      end else begin
         tx_pin_o <= tx_serial_i ^ tx_invert;
         tx_pin_oe_o <= single_wire ? tx_dir : 1'b1;
         rx_line_o <= line_level;
      end
   end

   // error interrupt request from the four enabled flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_irq_o <= 1'b0;
      end else begin
         err_irq_o <= (overrun_flag_i && irq_en[SCLX_C3_OR_IE]) ||
                      (noise_flag_i && irq_en[SCLX_C3_NF_IE]) ||
                      (framing_error_flag_i && irq_en[SCLX_C3_FE_IE]) ||
                      (parity_error_flag_i && irq_en[SCLX_C3_PF_IE]);
      end
   end

   // read views; bit 5 of the status register is unused and reads zero
   assign status_two = {brk_flag, edge_flag, 1'b0, rx_invert, idle_sel,
                        long_brk_sel, brk_det_en, rx_busy};
   assign control_three = {rx_ninth, tx_ninth, tx_dir, tx_invert, irq_en};

   // read data live for exactly one cycle after the strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i && reg_addr_i == SCLX_OFS_STATUS_TWO) begin
         reg_rdata_o <= status_two;
      end else if (reg_rd_i && reg_addr_i == SCLX_OFS_CONTROL_THREE) begin
         reg_rdata_o <= control_three;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // checks on the logic above
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_brk_hit;
      line_break && brk_det_en;
   endsequence
   sequence s_brk_w1c;
      wr_s2 && reg_wdata_i[SCLX_S2_BRK_FLAG];
   endsequence
   sequence s_ninth_load;
      char_accept && nine_bit_mode_i;
   endsequence
   // write-one strobes for the two sticky flags
   logic brk_w1c; // write of one to the break flag
   logic edge_w1c; // write of one to the edge flag
   assign brk_w1c = wr_s2 && reg_wdata_i[SCLX_S2_BRK_FLAG];
   assign edge_w1c = wr_s2 && reg_wdata_i[SCLX_S2_EDGE_FLAG];

   chk_brk_flag_set: assert property (s_brk_hit |=> brk_flag)
      else $error("break flag missed a detected break");
   chk_brk_flag_hold: assert property (brk_flag && !brk_w1c |=> brk_flag)
      else $error("break flag dropped without a write of one");
   chk_brk_flag_clr: assert property (s_brk_w1c and !line_break |=> !brk_flag)
      else $error("break flag not cleared by write of one");
   chk_edge_flag_set: assert property (line_edge |=> edge_flag ##1 edge_flag || $past(wr_s2))
      else $error("edge flag missed an active edge");
   chk_idle_gate: assert property (line_idle && receiver_standby_i && !idle_sel |=> !idle_set_o)
      else $error("idle set while standby without select");
   chk_break_len: assert property (##1 break_len_o ==
      sclx_len($past(nine_bit_mode_i), $past(long_brk_sel), SCLX_BRK_TX_SHORT,
               SCLX_BRK_TX_LONG))
      else $error("transmit break length wrong");
   chk_rx_suppress: assert property (rx_char_done_i && brk_det_en |=> !rx_full_set_o && !framing_set_o)
      else $error("receive flags set during break detection");
   chk_rx_active: assert property (line_edge && !rx_busy |=> rx_busy [*2])
      else $error("receiver active flag not set by start edge");
   chk_rx_ninth: assert property (s_ninth_load |=> rx_ninth == $past(rx_bit8_i))
      else $error("ninth receive bit not loaded");
   chk_tx_word: assert property (tx_data_wr_i && nine_bit_mode_i |=> tx_word_o == {$past(tx_ninth), $past(tx_data_i)})
      else $error("transmit word does not carry ninth bit");
   chk_tx_dir: assert property (single_wire && !tx_dir |=> !tx_pin_oe_o)
      else $error("transmit pin driven in single-wire input mode");
   chk_tx_invert: assert property (##1 tx_pin_o == ($past(tx_serial_i) ^ $past(tx_invert)))
      else $error("transmit pin polarity wrong");
   chk_err_irq: assert property (overrun_flag_i && irq_en[SCLX_C3_OR_IE] ##1 overrun_flag_i |-> err_irq_o)
      else $error("overrun interrupt not requested");
   chk_irq_quiet: assert property (irq_en == 4'h0 |=> !err_irq_o)
      else $error("interrupt requested with all enables clear");
   // each remaining error source raises the request on its own enable
   chk_nf_irq: assert property (noise_flag_i && irq_en[SCLX_C3_NF_IE] |=> err_irq_o)
      else $error("noise interrupt not requested");
   chk_fe_irq: assert property (framing_error_flag_i && irq_en[SCLX_C3_FE_IE] |=> err_irq_o)
      else $error("framing interrupt not requested");
   chk_pf_irq: assert property (parity_error_flag_i && irq_en[SCLX_C3_PF_IE] |=> err_irq_o)
      else $error("parity interrupt not requested");
   // clears are checked only without a same-cycle event, since set wins
   chk_edge_w1c: assert property (edge_w1c && !line_edge |=> !edge_flag)
      else $error("edge flag not cleared");
   chk_edge_hold: assert property (edge_flag && !edge_w1c |=> edge_flag)
      else $error("edge flag dropped");
   chk_ninth_ro: assert property (wr_c3 && !char_accept |=> $stable(rx_ninth))
      else $error("ninth receive bit written");
   chk_brk_refuse: assert property (!brk_flag && !brk_det_en |=> !brk_flag)
      else $error("break flag set while disabled");
   // character, idle and geometry outputs
   chk_rx_full: assert property (char_accept |=> rx_full_set_o)
      else $error("full flag request missing");
   chk_framing_set: assert property (char_accept && rx_stop_err_i |=> framing_set_o)
      else $error("framing request missing");
   chk_idle_pass: assert property (line_idle && idle_sel |=> idle_set_o)
      else $error("selected idle not reported");
   chk_active_clr: assert property (line_idle |=> !rx_busy)
      else $error("active flag not cleared by idle");
   chk_frame_bits: assert property (##1 frame_bits_o ==
      ($past(nine_bit_mode_i) ? SCLX_FRAME_BITS_9 : SCLX_FRAME_BITS_8))
      else $error("frame length wrong");
   chk_tx_word8: assert property (tx_data_wr_i && !nine_bit_mode_i |=>
      tx_word_o == {1'b0, $past(tx_data_i)})
      else $error("eight-bit word carries a ninth bit");
endmodule

/* tb/sclx_node.sv */
`timescale 1ns/1ns
// remote node on the serial pins: sends low runs of a set number of bit times
module sclx_node (
   input wire logic clk_i, // bus clock
   input wire logic bit_tick_i, // one pulse per bit time
   input wire logic go_i, // start a low run at the next bit time
   input wire logic [4:0] low_i, // run length in bit times
   input wire logic txd_i, // block's transmit drive value
   input wire logic txd_oe_i, // block's transmit drive enable
   output logic rx_pin_o, // receive line, high when idle
   output logic tx_wire_o // transmit wire level as read back
);
   logic arm = 1'b0; // run requested, waiting for a bit boundary
   logic [4:0] cnt = 5'h00; // bit times still to hold low
   // starting on a tick makes the block see exactly low_i low bit times
   always_ff @(posedge clk_i) begin
      if (go_i) begin
         arm <= 1'b1;
      end
      if (bit_tick_i && arm) begin
         arm <= 1'b0;
         cnt <= low_i;
      end else if (bit_tick_i && cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
   end
   assign rx_pin_o = (cnt == 5'h00);
   // a released wire is held at idle by this listening node
   assign tx_wire_o = txd_oe_i ? txd_i : 1'b1;
endmodule

/* tb/sclx_top_test.sv */
`timescale 1ns/1ns
module sclx_top_test;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b0, go = 1'b0;
   logic nine = 1'b0, lpm = 1'b0, lsrc = 1'b0, txs = 1'b1, dwr = 1'b0;
   logic done = 1'b0, serr = 1'b0, b8 = 1'b0, stby = 1'b0;
   logic [1:0] addr = 2'h0, tcnt = 2'h0; // register address, tick divider
   logic [7:0] wdata = 8'h00, txd = 8'h00, rdata;
   logic [3:0] errf = 4'h0, blen, fbits; // error flags: overrun, noise, framing, parity
   logic [4:0] low = 5'h00;
   logic rxp, txw, txo, txoe, irq, rxl, fset, feset, iset;
   logic [8:0] word;
   int fail_count = 0, checks = 0, idle_cnt = 0;
   sclx_top i_sclx_top (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_pin_i(rxp), .tx_pin_i(txw),
      .tx_pin_o(txo), .tx_pin_oe_o(txoe), .bit_tick_i(tick), .nine_bit_mode_i(nine),
      .loop_mode_i(lpm), .loop_source_select_i(lsrc), .receiver_standby_i(stby),
      .tx_serial_i(txs), .tx_data_i(txd), .tx_data_wr_i(dwr), .tx_word_o(word),
      .break_len_o(blen), .frame_bits_o(fbits), .rx_char_done_i(done),
      .rx_stop_err_i(serr), .rx_bit8_i(b8), .rx_line_o(rxl), .rx_full_set_o(fset),
      .framing_set_o(feset), .idle_set_o(iset), .overrun_flag_i(errf[3]),
      .noise_flag_i(errf[2]), .framing_error_flag_i(errf[1]), .parity_error_flag_i(errf[0]),
      .err_irq_o(irq));
   sclx_node i_sclx_node (.clk_i(clk), .bit_tick_i(tick), .go_i(go), .low_i(low),
      .txd_i(txo), .txd_oe_i(txoe), .rx_pin_o(rxp), .tx_wire_o(txw));
   initial forever #50 clk = ~clk;
   // one bit time is four bus clocks, short enough to keep break runs quick
   always @(posedge clk) begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
   end
   // idle requests last one cycle, so count them as they pass
   always @(posedge clk) begin
      if (iset) begin
         idle_cnt <= idle_cnt + 1;
      end
   end
   task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so sample there
   task automatic rchk(input string n, input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(n, rdata, e);
   endtask
   task automatic run_low(input logic [4:0] n);
      @(posedge clk);
      low <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic char_in();
      @(posedge clk);
      done <= 1'b1;
      serr <= 1'b1;
      b8 <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      @(negedge clk);
   endtask
   task automatic send(input logic [7:0] d);
      @(posedge clk);
      txd <= d;
      dwr <= 1'b1;
      @(posedge clk);
      dwr <= 1'b0;
      @(negedge clk);
   endtask
   // receiver fed from the internal stream in standby: low run, then idle
   task automatic idle_scn(input logic sel);
      int c0;
      c0 = idle_cnt;
      wreg(2'h0, {4'h4, sel, 3'h0});
      txs <= 1'b0;
      cyc(20);
      chk("tx follows", txo, 1'b0);
      chk("loop line", rxl, 1'b0);
      txs <= 1'b1;
      cyc(60);
      chk("idle pulses", 9'(idle_cnt - c0), {8'h00, sel});
   endtask
   task automatic test_done();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #500000;
      fail_count++;
      test_done();
   end
   initial begin
      cyc(12);
      rst <= 1'b0;
      rchk("status rst", 2'h0, 8'h00);
      rchk("unmapped", 2'h2, 8'h00);
      wreg(2'h0, 8'hef);
      rchk("status rw", 2'h0, 8'h0e);
      wreg(2'h1, 8'hff);
      rchk("control rw", 2'h1, 8'h7f);
      chk("tx inverted", txo, 1'b0);
      wreg(2'h1, 8'h00);
      cyc(2);
      chk("tx plain", txo, 1'b1);
      wreg(2'h0, 8'h10);
      cyc(4);
      chk("rx inverted", rxl, 1'b0);
      wreg(2'h0, 8'h40);
      cyc(50);
      rchk("idle clears", 2'h0, 8'h00);
      run_low(5'h02);
      cyc(8);
      rchk("edge set", 2'h0, 8'h41);
      wreg(2'h0, 8'h00);
      rchk("zero write", 2'h0, 8'h41);
      wreg(2'h0, 8'h40);
      rchk("edge clear", 2'h0, 8'h01);
      cyc(50);
      rchk("active clear", 2'h0, 8'h00);
      wreg(2'h0, 8'h02);
      run_low(5'h0a);
      cyc(100);
      rchk("ten low", 2'h0, 8'h42);
      wreg(2'h0, 8'h42);
      run_low(5'h0b);
      cyc(100);
      rchk("eleven low", 2'h0, 8'hc2);
      wreg(2'h0, 8'hc2);
      rchk("break clear", 2'h0, 8'h02);
      @(posedge clk);
      nine <= 1'b1;
      char_in();
      chk("full held", {feset, fset}, 2'h0);
      wreg(2'h0, 8'h04);
      char_in();
      chk("full framing", {feset, fset}, 2'h3);
      rchk("ninth rx", 2'h1, 8'h80);
      wreg(2'h1, 8'h40);
      send(8'ha5);
      chk("tx word", word, 9'h1a5);
      send(8'h3c);
      chk("tx word kept", word, 9'h13c);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         nine <= k[0];
         wreg(2'h0, k[1] ? 8'h04 : 8'h00);
         cyc(2);
         chk("break len", blen, 9'((k[1] ? 13 : 10) + k[0]));
         chk("frame bits", fbits, 9'(10 + k[0]));
      end
      lpm <= 1'b1;
      lsrc <= 1'b1;
      wreg(2'h1, 8'h00);
      cyc(2);
      chk("pin input", txoe, 1'b0);
      wreg(2'h1, 8'h20);
      cyc(2);
      chk("pin output", txoe, 1'b1);
      lpm <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         errf <= 4'(1 << i);
         wreg(2'h1, 8'(~(1 << i)) & 8'h0f);
         cyc(2);
         chk("irq masked", irq, 1'b0);
         wreg(2'h1, 8'(1 << i));
         cyc(2);
         chk("irq raised", irq, 1'b1);
      end
      stby <= 1'b1;
      lpm <= 1'b1;
      lsrc <= 1'b0;
      idle_scn(1'b0);
      idle_scn(1'b1);
      test_done();
   end
endmodule
